// [design/pll_clock_pkg.sv]
// Purpose: Shared constants for the PLL clock ratio control block
// Assumes: Register indices are word indices; byte address is index times four
// Notes: Write masks define which bits software may change per register

package pll_clock_pkg;

  // ********************************************************************
  // Bus and register map
  // ********************************************************************
  localparam int ADDR_W = 18;
  localparam int NUM_REGS = 13;
  localparam logic [15:0] IDX_CLOCK_OUT_PIN_CONTROL = 16'h7010;
  localparam logic [15:0] IDX_PLL_STATUS = 16'h7011;
  localparam logic [15:0] IDX_FAST_PERIPHERAL_PRESCALER = 16'h701a;
  localparam logic [15:0] IDX_SLOW_PERIPHERAL_PRESCALER = 16'h701b;
  localparam logic [15:0] IDX_PERIPHERAL_CLOCK_GATE_A = 16'h701c;
  localparam logic [15:0] IDX_PERIPHERAL_CLOCK_GATE_B = 16'h701d;
  localparam logic [15:0] IDX_LOW_POWER_MODE_CONTROL = 16'h701e;
  localparam logic [15:0] IDX_PLL_RATIO = 16'h7021;
  localparam logic [15:0] IDX_SYSTEM_CONTROL_STATUS = 16'h7022;
  localparam logic [15:0] IDX_WATCHDOG_COUNT = 16'h7023;
  localparam logic [15:0] IDX_WATCHDOG_SERVICE_KEY = 16'h7025;
  localparam logic [15:0] IDX_WATCHDOG_CONTROL = 16'h7029;
  localparam logic [15:0] IDX_WRITE_PROTECT = 16'h7030;
  // Slot order, slot 0 last
  localparam logic [NUM_REGS-1:0][15:0] REG_INDEX = {
    IDX_WRITE_PROTECT, IDX_WATCHDOG_CONTROL, IDX_WATCHDOG_SERVICE_KEY,
    IDX_WATCHDOG_COUNT, IDX_SYSTEM_CONTROL_STATUS, IDX_PLL_RATIO,
    IDX_LOW_POWER_MODE_CONTROL, IDX_PERIPHERAL_CLOCK_GATE_B,
    IDX_PERIPHERAL_CLOCK_GATE_A, IDX_SLOW_PERIPHERAL_PRESCALER,
    IDX_FAST_PERIPHERAL_PRESCALER, IDX_PLL_STATUS, IDX_CLOCK_OUT_PIN_CONTROL};
  localparam logic [NUM_REGS-1:0][15:0] WR_MASK = {
    16'h0001, 16'hffff, 16'hffff, 16'h0000, 16'hffff, 16'h000f,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0006, 16'hffff};
  localparam logic [3:0] SLOT_STATUS = 4'h1;
  localparam logic [3:0] SLOT_RATIO = 4'h7;
  localparam logic [3:0] SLOT_PROTECT = 4'hc;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ********************************************************************
  // Fields
  // ********************************************************************
  localparam int STS_LOCK_BIT = 0;
  localparam int STS_HALVE_BIT = 1;
  localparam int STS_OFF_BIT = 2;
  localparam int PROT_BIT = 0;
  localparam logic [3:0] RATIO_BYPASS = 4'h0;
  localparam logic [3:0] RATIO_MAX = 4'ha;
  localparam logic [3:0] MULT_ONE = 4'h1;
  localparam logic [1:0] DIV_ONE = 2'h1;
  localparam logic [1:0] DIV_TWO = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned LOCK_OSC_CYCLES = 131072;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'b00,
    MODE_RELOCK = 2'b01,
    MODE_ENABLED = 2'b10,
    MODE_OFF = 2'b11
  } pll_mode_t;

  typedef enum logic [1:0] {
    SRC_OSC = 2'b00,
    SRC_PLL = 2'b01,
    SRC_LIMP = 2'b10
  } clk_src_t;

endpackage : pll_clock_pkg

// [design/pll_clock_ratio_control.sv]
// Purpose: PLL ratio, halving and mode control with an AXI4-Lite register slave
// Assumes: clock_in is the oscillator clock; osc_present_in flags a live oscillator
// Notes: Clock outputs describe the selected multiplier, divider and source
// Functional notes
// - Four-bit ratio field selects oscillator multiplier
// - Zero bypasses, 1-10 multiply, rest reserved
// - Halving bit zero divides by two, one by one
// - System clock out equals core input clock
// - Lock reported after 131072 oscillator cycles
// - Ratio write forces bypass until lock
// - Reset gives bypass with ratio zero
// - Bypass keeps PLL powered, oscillator path used
// - Shutdown bit disables PLL, direct input clock
// - Protected registers written only in protected mode
// - Lost oscillator falls back to limp clock while PLL powered

`timescale 1ns/1ps
`default_nettype none

module pll_clock_ratio_control #(
  parameter int unsigned LOCK_CYCLES = pll_clock_pkg::LOCK_OSC_CYCLES
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [pll_clock_pkg::ADDR_W-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [pll_clock_pkg::ADDR_W-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic osc_present_in,
  output logic [1:0] core_source_out,
  output logic [3:0] core_mult_out,
  output logic [1:0] core_div_out,
  output logic [3:0] system_clock_mult_out,
  output logic [1:0] system_clock_div_out,
  output logic pll_powered_out,
  output logic lock_done_flag_out
);

  localparam int CW = $clog2(LOCK_CYCLES + 1);
  localparam int AW = pll_clock_pkg::ADDR_W;
  localparam int NR = pll_clock_pkg::NUM_REGS;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [NR-1:0][15:0] regs;
    pll_clock_pkg::pll_mode_t mode;
    logic [CW-1:0] lock_cnt;
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    pll_clock_pkg::clk_src_t src;
    logic [3:0] mult;
    logic [1:0] div;
    logic [3:0] sys_mult;
    logic [1:0] sys_div;
    logic powered;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic wr_fire;
  logic wr_hit;
  logic [3:0] wr_slot;
  logic wr_ok;
  logic ratio_wr;
  logic rd_hit;
  logic [3:0] rd_slot;

  // Returns hit in bit 4 and slot in bits 3:0
  function automatic logic [4:0] find_slot(input logic [AW-1:0] a);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < NR; i++) begin
      if (a[AW-1:2] == pll_clock_pkg::REG_INDEX[i] && a[1:0] == 2'b00) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : find_slot

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin : next_state
    logic [15:0] mask;
    logic [3:0] ratio;
    logic ratio_ok;
    logic shut;
    nxt_st = st_ff;
    mask = 16'h0000;
    ratio = 4'h0;
    ratio_ok = 1'b0;
    shut = 1'b0;
    {wr_hit, wr_slot} = find_slot(st_ff.aw_addr);
    {rd_hit, rd_slot} = find_slot(axi_araddr_in);
    wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    wr_ok = 1'b0;
    ratio_wr = 1'b0;

    // Address and data are caught independently, in either order
    if (axi_awvalid_in && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = axi_awaddr_in;
    end
    if (axi_wvalid_in && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = axi_wdata_in[15:0];
      nxt_st.w_strb = axi_wstrb_in[1:0];
    end
    if (st_ff.bvalid && axi_bready_in) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      // Protect register itself stays writable, else no way out
      wr_ok = wr_hit && (wr_slot == pll_clock_pkg::SLOT_PROTECT ||
              st_ff.regs[pll_clock_pkg::SLOT_PROTECT][pll_clock_pkg::PROT_BIT]);
      if (wr_ok) begin
        mask = pll_clock_pkg::WR_MASK[wr_slot] &
               {{8{st_ff.w_strb[1]}}, {8{st_ff.w_strb[0]}}};
        nxt_st.regs[wr_slot] = (st_ff.regs[wr_slot] & ~mask) | (st_ff.w_data & mask);
        ratio_wr = (wr_slot == pll_clock_pkg::SLOT_RATIO);
      end
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_hit ? pll_clock_pkg::RESP_OKAY : pll_clock_pkg::RESP_DECERR;
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

    // Read path answers one cycle after the address is taken
    if (st_ff.rvalid && axi_rready_in) begin
      nxt_st.rvalid = 1'b0;
    end
    if (axi_arvalid_in && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_hit ? {16'h0000, st_ff.regs[rd_slot]} : 32'h0000_0000;
      nxt_st.rresp = rd_hit ? pll_clock_pkg::RESP_OKAY : pll_clock_pkg::RESP_DECERR;
    end
    nxt_st.arready = !nxt_st.rvalid;

    // PLL lock sequencing
    ratio = nxt_st.regs[pll_clock_pkg::SLOT_RATIO][3:0];
    shut = nxt_st.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_OFF_BIT];
    ratio_ok = ratio != pll_clock_pkg::RATIO_BYPASS &&
               ratio <= pll_clock_pkg::RATIO_MAX;
    case (st_ff.mode)
      pll_clock_pkg::MODE_RELOCK: begin
        if (st_ff.lock_cnt == CW'(1)) begin
          nxt_st.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_LOCK_BIT] = 1'b1;
          nxt_st.mode = ratio_ok ? pll_clock_pkg::MODE_ENABLED : pll_clock_pkg::MODE_BYPASS;
        end else begin
          nxt_st.lock_cnt = st_ff.lock_cnt - CW'(1);
        end
      end
      pll_clock_pkg::MODE_OFF: begin
        // Powering back up needs a fresh lock
        if (!shut) begin
          nxt_st.mode = pll_clock_pkg::MODE_RELOCK;
          nxt_st.lock_cnt = CW'(LOCK_CYCLES);
        end
      end
      pll_clock_pkg::MODE_BYPASS, pll_clock_pkg::MODE_ENABLED: begin
        nxt_st.mode = st_ff.mode;
      end
      default: begin
        nxt_st.mode = pll_clock_pkg::MODE_BYPASS;
      end
    endcase
    // A stale lock must not survive a new ratio, so the clear wins here
    if (ratio_wr) begin
      nxt_st.mode = pll_clock_pkg::MODE_RELOCK;
      nxt_st.lock_cnt = CW'(LOCK_CYCLES);
      nxt_st.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_LOCK_BIT] = 1'b0;
    end
    if (shut) begin
      nxt_st.mode = pll_clock_pkg::MODE_OFF;
      nxt_st.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_LOCK_BIT] = 1'b0;
    end

    // Clock selection
    nxt_st.powered = nxt_st.mode != pll_clock_pkg::MODE_OFF;
    if (nxt_st.mode == pll_clock_pkg::MODE_ENABLED && ratio_ok) begin
      nxt_st.mult = ratio;
      nxt_st.src = pll_clock_pkg::SRC_PLL;
    end else begin
      nxt_st.mult = pll_clock_pkg::MULT_ONE;
      nxt_st.src = pll_clock_pkg::SRC_OSC;
    end
    // Limp clock exists only while the PLL is powered
    if (!osc_present_in && nxt_st.powered) begin
      nxt_st.src = pll_clock_pkg::SRC_LIMP;
      nxt_st.mult = pll_clock_pkg::MULT_ONE;
    end
    nxt_st.div = nxt_st.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_HALVE_BIT] ?
                 pll_clock_pkg::DIV_ONE : pll_clock_pkg::DIV_TWO;
    nxt_st.sys_mult = nxt_st.mult;
    nxt_st.sys_div = nxt_st.div;
  end : next_state

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clock_in) begin : state_reg
    if (sys_rst_in) begin
      st_ff <= '0;
      st_ff.regs <= {NR{pll_clock_pkg::REG_RESET}};
      st_ff.mode <= pll_clock_pkg::MODE_RELOCK;
      st_ff.lock_cnt <= CW'(LOCK_CYCLES);
      st_ff.src <= pll_clock_pkg::SRC_OSC;
      st_ff.mult <= pll_clock_pkg::MULT_ONE;
      st_ff.div <= pll_clock_pkg::DIV_TWO;
      st_ff.sys_mult <= pll_clock_pkg::MULT_ONE;
      st_ff.sys_div <= pll_clock_pkg::DIV_TWO;
      st_ff.powered <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end : state_reg

  assign axi_awready_out = st_ff.awready;
  assign axi_wready_out = st_ff.wready;
  assign axi_bvalid_out = st_ff.bvalid;
  assign axi_bresp_out = st_ff.bresp;
  assign axi_arready_out = st_ff.arready;
  assign axi_rvalid_out = st_ff.rvalid;
  assign axi_rdata_out = st_ff.rdata;
  assign axi_rresp_out = st_ff.rresp;
  assign core_source_out = st_ff.src;
  assign core_mult_out = st_ff.mult;
  assign core_div_out = st_ff.div;
  assign system_clock_mult_out = st_ff.sys_mult;
  assign system_clock_div_out = st_ff.sys_div;
  assign pll_powered_out = st_ff.powered;
  assign lock_done_flag_out = st_ff.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_LOCK_BIT];

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  ratio_write_bypass_a: assert property (
    ratio_wr |=> core_source_out != pll_clock_pkg::SRC_PLL &&
                 core_mult_out == pll_clock_pkg::MULT_ONE)
    else $error("ratio write did not force bypass");

  lock_clear_a: assert property (
    ratio_wr |=> !lock_done_flag_out [*3])
    else $error("lock flag not cleared by ratio write");

  lock_count_a: assert property (
    st_ff.mode == pll_clock_pkg::MODE_RELOCK && st_ff.lock_cnt == CW'(1) &&
    !ratio_wr && !nxt_st.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_OFF_BIT]
    |=> lock_done_flag_out)
    else $error("lock not reported when count ended");

  reset_bypass_a: assert property (@(posedge clock_in) disable iff (1'b0)
    sys_rst_in |=> st_ff.regs[pll_clock_pkg::SLOT_RATIO] == 16'h0000 &&
                   core_source_out == pll_clock_pkg::SRC_OSC && !lock_done_flag_out)
    else $error("reset did not give bypass");

  halving_div_a: assert property (
    core_div_out == (st_ff.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_HALVE_BIT] ?
                     pll_clock_pkg::DIV_ONE : pll_clock_pkg::DIV_TWO))
    else $error("core divider does not follow halving bit");

  sysclk_same_a: assert property (
    system_clock_mult_out == core_mult_out && system_clock_div_out == core_div_out)
    else $error("system clock differs from core clock");

  protect_ignore_a: assert property (
    wr_fire && wr_slot == pll_clock_pkg::SLOT_RATIO &&
    !st_ff.regs[pll_clock_pkg::SLOT_PROTECT][pll_clock_pkg::PROT_BIT]
    |=> $stable(st_ff.regs[pll_clock_pkg::SLOT_RATIO]))
    else $error("protected register changed outside protected mode");

  shutdown_direct_a: assert property (
    st_ff.regs[pll_clock_pkg::SLOT_STATUS][pll_clock_pkg::STS_OFF_BIT]
    |-> !pll_powered_out && core_source_out == pll_clock_pkg::SRC_OSC &&
        core_mult_out == pll_clock_pkg::MULT_ONE)
    else $error("shutdown did not give direct input clock");

  ratio_apply_a: assert property (
    core_source_out == pll_clock_pkg::SRC_PLL
    |-> core_mult_out == st_ff.regs[pll_clock_pkg::SLOT_RATIO][3:0] &&
        core_mult_out <= pll_clock_pkg::RATIO_MAX && lock_done_flag_out)
    else $error("multiplied clock with bad ratio or no lock");

  limp_fallback_a: assert property (
    !osc_present_in && nxt_st.powered |=> core_source_out == pll_clock_pkg::SRC_LIMP)
    else $error("no limp clock on oscillator loss");

endmodule : pll_clock_ratio_control

`default_nettype wire

// [bench/pll_clock_ratio_control_tb.sv]
// Purpose: Self-checking bench for the PLL ratio control block
// Assumes: LOCK_CYCLES shortened to 8; byte address is register index times four
// Notes: Reference model keeps register contents and the protect bit

`timescale 1ns/1ps
`default_nettype none

module pll_clock_ratio_control_tb;
  localparam int LOCK = 8;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, osc_ok = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, powered, lock;
  logic [1:0] bresp, rresp, src, div, sdiv;
  logic [3:0] mult, smult;
  logic [31:0] rdata;
  int err_count = 0;
  int compares = 0;
  logic [15:0] mdl [logic [15:0]];
  bit prot = 0;
  // Plain storage registers, status and ratio are exercised separately
  logic [15:0] sto [10] = '{16'h7010, 16'h701a, 16'h701b, 16'h701c, 16'h701d,
    16'h701e, 16'h7022, 16'h7023, 16'h7025, 16'h7029};

  pll_clock_ratio_control #(.LOCK_CYCLES(LOCK)) dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
    .axi_wdata_in(wdata), .axi_wstrb_in(wstrb), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
    .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
    .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready), .osc_present_in(osc_ok),
    .core_source_out(src), .core_mult_out(mult), .core_div_out(div),
    .system_clock_mult_out(smult), .system_clock_div_out(sdiv),
    .pll_powered_out(powered), .lock_done_flag_out(lock));

  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // ********************************************************************
  // Checking and bus tasks
  // ********************************************************************
  task automatic print_verdict();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] wmask(input logic [15:0] i);
    case (i)
      16'h7011: return 16'h0006;
      16'h7021: return 16'h000f;
      16'h7023: return 16'h0000;
      16'h7030: return 16'h0001;
      default: return 16'hffff;
    endcase
  endfunction : wmask

  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge clock_in);
    awaddr <= {i, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clock_in);
      if (!a && awready === 1'b1) begin
        a = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clock_in);
    bready <= 1'b0;
    chk(bresp, mdl.exists(i) ? 2'h0 : 2'h3, "bresp");
    // Protect bit itself is never locked; the rest only while it is set
    if (i == 16'h7030) begin
      prot = d[0];
      mdl[i] = d & 16'h0001;
    end else if (prot && mdl.exists(i)) begin
      mdl[i] = (mdl[i] & ~wmask(i)) | (d & wmask(i));
    end
  endtask : wr

  task automatic rd(input logic [15:0] i);
    logic [31:0] exp;
    @(posedge clock_in);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock_in);
    rready <= 1'b0;
    exp = mdl.exists(i) ? {16'h0000, mdl[i]} : 32'h0000_0000;
    chk(rresp, mdl.exists(i) ? 2'h0 : 2'h3, "rresp");
    // Lock flag in status bit 0 is checked at its port instead
    chk(i == 16'h7011 ? rdata & 32'hffff_fffe : rdata, exp, "rdata");
  endtask : rd

  task automatic outs(input logic [1:0] s, input logic [3:0] m, input logic [1:0] d,
                      input logic l, input logic p);
    chk({src, mult, div, smult, sdiv, lock, powered}, {s, m, d, m, d, l, p}, "clock outs");
  endtask : outs

  task automatic wait_lock();
    int n;
    n = 0;
    while (lock !== 1'b1 && n < 4 * LOCK) begin
      @(posedge clock_in);
      n++;
    end
    chk(n >= LOCK - 1 && n <= LOCK + 2, 1, "lock delay");
  endtask : wait_lock

  task automatic ratio_step(input logic [3:0] r);
    bit en;
    en = r >= 4'h1 && r <= 4'ha;
    wr(16'h7021, {12'h000, r});
    #1 outs(2'b00, 4'h1, 2'h2, 1'b0, 1'b1);
    wait_lock();
    @(posedge clock_in);
    #1 outs(en ? 2'b01 : 2'b00, en ? r : 4'h1, 2'h2, 1'b1, 1'b1);
    wr(16'h7011, 16'h0002);
    @(posedge clock_in);
    #1 outs(en ? 2'b01 : 2'b00, en ? r : 4'h1, 2'h1, 1'b1, 1'b1);
    wr(16'h7011, 16'h0000);
  endtask : ratio_step

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    void'($urandom(32'h0000_8d8e));
    foreach (sto[k]) mdl[sto[k]] = 16'h0000;
    mdl[16'h7011] = 16'h0000;
    mdl[16'h7021] = 16'h0000;
    mdl[16'h7030] = 16'h0000;
    repeat (3) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    #1 outs(2'b00, 4'h1, 2'h2, 1'b0, 1'b1);
    wait_lock();
    rd(16'h7021);
    rd(16'h7011);
    foreach (sto[k]) rd(sto[k]);
    rd(16'h7012);
    wr(16'h7012, 16'hffff);
    foreach (sto[k]) wr(sto[k], 16'($urandom));
    foreach (sto[k]) rd(sto[k]);
    wr(16'h7021, 16'h0005);
    @(posedge clock_in);
    #1 outs(2'b00, 4'h1, 2'h2, 1'b1, 1'b1);
    wr(16'h7030, 16'h0001);
    rd(16'h7030);
    foreach (sto[k]) wr(sto[k], 16'($urandom));
    foreach (sto[k]) rd(sto[k]);
    wr(16'h7029, 16'h0000);
    for (int r = 0; r < 16; r++) ratio_step(4'(r));
    rd(16'h7021);
    wr(16'h7021, 16'h0003);
    wr(16'h7021, 16'h0007);
    wait_lock();
    @(posedge clock_in);
    #1 outs(2'b01, 4'h7, 2'h2, 1'b1, 1'b1);
    wr(16'h7021, 16'h0000);
    wait_lock();
    wr(16'h7011, 16'h0004);
    @(posedge clock_in);
    #1 outs(2'b00, 4'h1, 2'h2, 1'b0, 1'b0);
    rd(16'h7011);
    wr(16'h7011, 16'h0000);
    wait_lock();
    wr(16'h7021, 16'h0006);
    wait_lock();
    @(posedge clock_in);
    osc_ok <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1 outs(2'b10, 4'h1, 2'h2, 1'b1, 1'b1);
    @(posedge clock_in);
    osc_ok <= 1'b1;
    @(posedge clock_in);
    #1 outs(2'b01, 4'h6, 2'h2, 1'b1, 1'b1);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    foreach (mdl[k]) mdl[k] = 16'h0000;
    prot = 0;
    @(posedge clock_in);
    #1 outs(2'b00, 4'h1, 2'h2, 1'b0, 1'b1);
    rd(16'h7021);
    rd(16'h7030);
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clock_in);
    err_count++;
    $display("FAIL t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule : pll_clock_ratio_control_tb

`default_nettype wire
